// *** rcr_chk_sva.sv ***
// Checker for the reset cause recorder: event answers and bus handshakes.
// Assumes binding to the top module, one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module rcr_chk_sva #(
	parameter PC_W = 16
) (
	input wire i_mclk,
	input wire i_rst,
	input wire i_power_on,
	input wire i_brownout,
	input wire i_external_reset_pin,
	input wire i_wdt_timeout,
	input wire i_wdt_window,
	input wire i_reset_instr,
	input wire i_stack_overflow,
	input wire i_stack_underflow,
	input wire i_irq_wake,
	input wire i_sleep_enter,
	input wire [PC_W-1:0] i_pc,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire [PC_W-1:0] o_resume_pc,
	input wire o_resume_valid,
	input wire o_core_reset,
	input wire o_irq_vector_pending
);
// ****
// Properties
// ****
default clocking @(posedge i_mclk); endclocking
default disable iff (i_rst);
wire rst_ev = i_power_on | i_brownout | i_wdt_window | i_reset_instr;
wire oth_ev = rst_ev | i_external_reset_pin | i_wdt_timeout | i_stack_overflow | i_stack_underflow;
// Sleep entry never answers, but it is counted as a cause as well
wire any_ev = oth_ev | i_irq_wake | i_sleep_enter;
AST_RST_PC: assert property (rst_ev |=> o_core_reset && o_resume_pc == 0)
	else $error("reset event without restart at zero");
AST_WAKE: assert property (i_irq_wake && !oth_ev |=> !o_core_reset && o_resume_valid
	&& o_resume_pc == $past(i_pc) + 1'b1)
	else $error("wake did not continue at next address");
AST_VEC: assert property (o_irq_vector_pending |=> o_resume_valid && o_resume_pc == 16'h0004)
	else $error("vector not loaded after wake");
AST_VEC_SRC: assert property (o_irq_vector_pending |-> $past(i_irq_wake))
	else $error("vector pending without wake");
AST_NOEV: assert property (!any_ev && !o_irq_vector_pending |=> !o_resume_valid)
	else $error("resume strobe without cause");
AST_CR: assert property (o_core_reset |-> o_resume_valid && o_resume_pc == 0)
	else $error("core reset without restart");
AST_AW: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
	|-> ##[1:2] s_axi_bvalid)
	else $error("write not answered");
AST_AR: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
	else $error("read not answered");
cover property (o_irq_vector_pending);
cover property (o_core_reset);
cover property (i_irq_wake && !oth_ev);
endmodule
`default_nettype wire

// *** rcr_consts.vh ***
// Constants for the reset cause recorder: register offsets, bit positions, reset values.
// Assumes inclusion by bare name from the design file.
`ifndef RCR_CONSTS_VH
`define RCR_CONSTS_VH
`define RCR_OFF_CAUSE 8'h00
`define RCR_OFF_STATUS 8'h04
`define RCR_OFF_PC 8'h08
`define RCR_OFF_CTRL 8'h0c
`define RCR_OFF_IRQ_STAT 8'h10
`define RCR_OFF_IRQ_EN 8'h14
`define RCR_OFF_IRQ_CLR 8'h18
`define RCR_B_STKOV 7
`define RCR_B_STKUN 6
`define RCR_B_WINV 5
`define RCR_B_WDRST 4
`define RCR_B_PIN 3
`define RCR_B_INSTR 2
`define RCR_B_POWER 1
`define RCR_B_BROWN 0
`define RCR_B_EXPIRY 4
`define RCR_B_SLEEP 3
`define RCR_STATUS_MASK 8'h1f
`define RCR_RESET_VEC 16'h0000
`define RCR_IRQ_VEC 16'h0004
`define RCR_CAUSE_POR 8'h1c
`define RCR_NEV 9
`endif

// *** rcr_reset_cause_recorder.v ***
// Reset cause recorder: cause flags, core status flags and restart address per event.
// Assumes event inputs are one-cycle pulses from logic on i_mclk; software over AXI4-Lite.
//
// Function
// [R1] Every reset updates cause flags; pin (running), instr and stack resets leave status
// [R2] Cause bits: ovf,unf,window,wdt,pin,instr,power,brown
// [R3] Status: expiry bit4, sleep bit3, bits 7:5 zero
// [R4] Power-on: PC zero, set expiry/sleep, fixed causes; code keeps the old brown flag
// [R5] Expiry and sleep read one after power-on
// [R6] Brown-out: PC zero, clear brown, keep power
// [R7] Watchdog reset: clear watchdog flag and expiry
// [R8] Watchdog in sleep: no reset, PC+1
// [R9] Window violation: clear window, watchdog, expiry
// [R10] Interrupt wake: expiry set, sleep clear, PC+1
// [R11] Wake with irq enabled: next, then vector
// [R12] Pin reset running: clear pin flag only
// [R13] Pin reset asleep: clear pin, expiry one, sleep zero
// [R14] Reset instruction: clear instruction flag only
// [R15] Enabled stack overflow: set overflow flag
// [R16] Enabled stack underflow: set underflow flag
// [R17] Firmware writes flags; held until next event
`timescale 1ns/10ps
`default_nettype none
`include "rcr_consts.vh"
module rcr_reset_cause_recorder #(
	parameter PC_W = 16
) (
	input wire i_mclk,
	input wire i_rst,
	input wire i_power_on,
	input wire i_brownout,
	input wire i_external_reset_pin,
	input wire i_wdt_timeout,
	input wire i_wdt_window,
	input wire i_reset_instr,
	input wire i_stack_overflow,
	input wire i_stack_underflow,
	input wire i_irq_wake,
	input wire i_sleep_enter,
	input wire [PC_W-1:0] i_pc,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	output wire [PC_W-1:0] o_resume_pc,
	output wire o_resume_valid,
	output wire o_core_reset,
	output wire o_irq_vector_pending,
	output wire o_irq
);

	// ************************************************************
	// Register state
	// ************************************************************
	reg [7:0] cause_q;
	reg [7:0] cause_d;
	reg [1:0] stat_q;
	reg [1:0] stat_d;
	reg [PC_W-1:0] pc_q;
	reg [PC_W-1:0] pc_d;
	reg rv_q;
	reg rv_d;
	reg crst_q;
	reg crst_d;
	reg vec_q;
	reg vec_d;
	reg stk_en_q;
	reg irq_glb_q;
	reg asleep_q;
	reg [`RCR_NEV-1:0] ist_q;
	reg [`RCR_NEV-1:0] ien_q;
	reg aw_q;
	reg w_q;
	reg [7:0] awa_q;
	reg [31:0] wd_q;
	reg [3:0] ws_q;
	reg bv_q;
	reg rv_bus_q;
	reg [31:0] rd_q;
	reg [1:0] rr_q;
	reg [1:0] br_q;

	wire [`RCR_NEV-1:0] ev;
	wire wr_go;
	wire [7:0] stat_rd;

	assign ev = {i_sleep_enter, i_irq_wake, i_stack_underflow & stk_en_q,
		i_stack_overflow & stk_en_q, i_reset_instr, i_wdt_window, i_wdt_timeout,
		i_external_reset_pin, i_brownout | i_power_on};
	assign stat_rd = {3'h0, stat_q[1], stat_q[0], 3'h0}; // R3
	assign wr_go = aw_q & w_q & ~bv_q;

	// ************************************************************
	// Event handling
	// ************************************************************
	// Earlier branches of the else-if chain win when events coincide; power-on dominates all.
	always @*
	begin
		cause_d = cause_q;
		stat_d = stat_q;
		pc_d = pc_q;
		rv_d = 1'b0;
		crst_d = 1'b0;
		vec_d = 1'b0;
		if (wr_go && awa_q == `RCR_OFF_CAUSE && ws_q[0])
			cause_d = wd_q[7:0]; // R17
		if (wr_go && awa_q == `RCR_OFF_STATUS && ws_q[0])
			stat_d = {wd_q[`RCR_B_EXPIRY], wd_q[`RCR_B_SLEEP]}; // R17
		if (i_sleep_enter)
			stat_d = 2'b10;
		if (vec_q)
		begin
			pc_d = `RCR_IRQ_VEC; // R11
			rv_d = 1'b1;
		end
		if (i_power_on)
		begin
			cause_d = `RCR_CAUSE_POR | (cause_q & 8'h01); // R4
			stat_d = 2'b11; // R5
			pc_d = `RCR_RESET_VEC;
			rv_d = 1'b1;
			crst_d = 1'b1;
		end
		else if (i_brownout)
		begin
			cause_d = {2'b00, cause_q[5], 3'b111, cause_q[1], 1'b0}; // R6
			cause_d[`RCR_B_WDRST] = 1'b1;
			stat_d = 2'b11;
			pc_d = `RCR_RESET_VEC;
			rv_d = 1'b1;
			crst_d = 1'b1;
		end
		else if (i_wdt_window)
		begin
			cause_d[`RCR_B_WINV] = 1'b0; // R9
			cause_d[`RCR_B_WDRST] = 1'b0;
			stat_d[1] = 1'b0;
			pc_d = `RCR_RESET_VEC;
			rv_d = 1'b1;
			crst_d = 1'b1;
		end
		else if (i_wdt_timeout && asleep_q)
		begin
			stat_d = 2'b00; // R8
			pc_d = i_pc + 1'b1;
			rv_d = 1'b1;
		end
		else if (i_wdt_timeout)
		begin
			cause_d[`RCR_B_WDRST] = 1'b0; // R7
			stat_d[1] = 1'b0;
			pc_d = `RCR_RESET_VEC;
			rv_d = 1'b1;
			crst_d = 1'b1;
		end
		else if (i_external_reset_pin)
		begin
			cause_d[`RCR_B_PIN] = 1'b0; // R12
			if (asleep_q)
				stat_d = 2'b10; // R13
			pc_d = `RCR_RESET_VEC;
			rv_d = 1'b1;
			crst_d = 1'b1;
		end
		else if (i_reset_instr)
		begin
			cause_d[`RCR_B_INSTR] = 1'b0; // R14
			pc_d = `RCR_RESET_VEC;
			rv_d = 1'b1;
			crst_d = 1'b1;
		end
		else if (i_stack_overflow && stk_en_q)
		begin
			cause_d[`RCR_B_STKOV] = 1'b1; // R15
			pc_d = `RCR_RESET_VEC;
			rv_d = 1'b1;
			crst_d = 1'b1;
		end
		else if (i_stack_underflow && stk_en_q)
		begin
			cause_d[`RCR_B_STKUN] = 1'b1; // R16
			pc_d = `RCR_RESET_VEC;
			rv_d = 1'b1;
			crst_d = 1'b1;
		end
		else if (i_irq_wake && asleep_q)
		begin
			stat_d = 2'b10; // R10
			pc_d = i_pc + 1'b1;
			rv_d = 1'b1;
			vec_d = irq_glb_q; // R11
		end
	end

	// R1
	always @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			cause_q <= `RCR_CAUSE_POR;
			stat_q <= 2'b11;
			pc_q <= `RCR_RESET_VEC;
			rv_q <= 1'b0;
			crst_q <= 1'b0;
			vec_q <= 1'b0;
			asleep_q <= 1'b0;
		end
		else
		begin
			cause_q <= cause_d;
			stat_q <= stat_d;
			pc_q <= pc_d;
			rv_q <= rv_d;
			crst_q <= crst_d;
			vec_q <= vec_d;
			// Sleep ends on any wake or reset; a same-cycle wake or reset wins over entry
			if (rv_d)
				asleep_q <= 1'b0;
			else if (i_sleep_enter)
				asleep_q <= 1'b1;
		end
	end

	assign o_resume_pc = pc_q;
	assign o_resume_valid = rv_q;
	assign o_core_reset = crst_q;
	assign o_irq_vector_pending = vec_q;

	// ************************************************************
	// Interrupt status, enable, clear
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < `RCR_NEV; g = g + 1)
		begin : g_ist
			always @(posedge i_mclk)
			begin
				if (i_rst)
					ist_q[g] <= 1'b0;
				else if (ev[g])
					ist_q[g] <= 1'b1;
				else if (wr_go && awa_q == `RCR_OFF_IRQ_CLR && wd_q[g])
					ist_q[g] <= 1'b0;
			end
		end
	endgenerate
	assign o_irq = |(ist_q & ien_q);

	// ************************************************************
	// AXI4-Lite slave
	// ************************************************************
	// Address and data latched independently; response once both held.
	assign s_axi_awready = ~aw_q;
	assign s_axi_wready = ~w_q;
	assign s_axi_bvalid = bv_q;
	assign s_axi_bresp = br_q;
	assign s_axi_arready = ~rv_bus_q;
	assign s_axi_rvalid = rv_bus_q;
	assign s_axi_rdata = rd_q;
	assign s_axi_rresp = rr_q;

	always @(posedge i_mclk)
	begin
		if (i_rst)
		begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awa_q <= 8'h00;
			wd_q <= 32'h0;
			ws_q <= 4'h0;
			bv_q <= 1'b0;
			br_q <= 2'b00;
			stk_en_q <= 1'b1;
			irq_glb_q <= 1'b0;
			ien_q <= {`RCR_NEV{1'b0}};
			rv_bus_q <= 1'b0;
			rd_q <= 32'h0;
			rr_q <= 2'b00;
		end
		else
		begin
			if (s_axi_awvalid && !aw_q)
			begin
				aw_q <= 1'b1;
				awa_q <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && !w_q)
			begin
				w_q <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end
			if (wr_go)
			begin
				bv_q <= 1'b1;
				br_q <= 2'b00;
				case (awa_q)
					`RCR_OFF_CAUSE, `RCR_OFF_STATUS, `RCR_OFF_IRQ_CLR:
						br_q <= 2'b00;
					`RCR_OFF_CTRL:
						if (ws_q[0])
						begin
							stk_en_q <= wd_q[0];
							irq_glb_q <= wd_q[1];
						end
					`RCR_OFF_IRQ_EN:
						if (ws_q[1] && ws_q[0])
							ien_q <= wd_q[`RCR_NEV-1:0];
					default:
						br_q <= 2'b10;
				endcase
			end
			if (bv_q && s_axi_bready)
			begin
				bv_q <= 1'b0;
				aw_q <= 1'b0;
				w_q <= 1'b0;
			end
			if (s_axi_arvalid && !rv_bus_q)
			begin
				rv_bus_q <= 1'b1;
				rr_q <= 2'b00;
				case (s_axi_araddr[7:0])
					`RCR_OFF_CAUSE: rd_q <= {24'h0, cause_q}; // R2
					`RCR_OFF_STATUS: rd_q <= {24'h0, stat_rd & `RCR_STATUS_MASK};
					`RCR_OFF_PC: rd_q <= {{(32-PC_W){1'b0}}, pc_q};
					`RCR_OFF_CTRL: rd_q <= {30'h0, irq_glb_q, stk_en_q};
					`RCR_OFF_IRQ_STAT: rd_q <= {{(32-`RCR_NEV){1'b0}}, ist_q};
					`RCR_OFF_IRQ_EN: rd_q <= {{(32-`RCR_NEV){1'b0}}, ien_q};
					`RCR_OFF_IRQ_CLR: rd_q <= 32'h0;
					default:
					begin
						rd_q <= 32'h0;
						rr_q <= 2'b10;
					end
				endcase
			end
			else if (rv_bus_q && s_axi_rready)
				rv_bus_q <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// *** rcr_reset_cause_recorder_tb.sv ***
// Testbench for the reset cause recorder: bus tasks, event pulses, checks.
// Assumes the design and its constants header are compiled first.
`timescale 1ns/10ps
`default_nettype none
module rcr_reset_cause_recorder_tb;
logic i_mclk = 1'h0;
logic i_rst = 1'h1;
logic [9:0] ev = 10'h0;
logic [15:0] pc = 16'h00a5;
logic [31:0] aa = 32'h0, wd = 32'h0, ra = 32'h0;
logic awv = 1'h0, wv = 1'h0, bp = 1'h0, arv = 1'h0, rp = 1'h0;
logic [1:0] rsp, bsp;
logic gx = 1'h0;
wire awr, wr_r, bv, arr, rv, rvld, crst, irq, vec;
wire [1:0] rrs, brs;
wire [31:0] rd_d;
wire [15:0] rpc;
int n_errors = 0;
int compares = 0;
always #25 i_mclk = ~i_mclk;
rcr_reset_cause_recorder dut (.i_mclk(i_mclk), .i_rst(i_rst),
	.i_power_on(ev[0]), .i_brownout(ev[1]), .i_external_reset_pin(ev[2]),
	.i_wdt_timeout(ev[3]), .i_wdt_window(ev[4]), .i_reset_instr(ev[5]),
	.i_stack_overflow(ev[6]), .i_stack_underflow(ev[7]), .i_irq_wake(ev[8]),
	.i_sleep_enter(ev[9]), .i_pc(pc), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
	.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
	.s_axi_wready(wr_r), .s_axi_bresp(brs), .s_axi_bvalid(bv), .s_axi_bready(bp),
	.s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd_d),
	.s_axi_rresp(rrs), .s_axi_rvalid(rv), .s_axi_rready(rp), .o_resume_pc(rpc),
	.o_resume_valid(rvld), .o_core_reset(crst), .o_irq_vector_pending(vec), .o_irq(irq));
// ****
// Tasks
// ****
task results;
	begin
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	end
endtask
task chk(input logic [31:0] g, input logic [31:0] e);
	begin
		compares++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	end
endtask
// Ready is looked at mid-cycle, where it equals its value at the next edge
task wr(input logic [7:0] a, input logic [31:0] d);
	logic ad, dd;
	begin
		ad = 1'h0;
		dd = 1'h0;
		@(posedge i_mclk);
		aa <= {24'h0, a};
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		bp <= 1'h1;
		while (!(ad && dd))
		begin
			@(negedge i_mclk);
			ad = ad | (awv & awr);
			dd = dd | (wv & wr_r);
			@(posedge i_mclk);
			if (ad) awv <= 1'h0;
			if (dd) wv <= 1'h0;
		end
		do @(negedge i_mclk); while (!bv);
		bsp = brs;
		@(posedge i_mclk);
		bp <= 1'h0;
	end
endtask
task rdc(input logic [7:0] a, input logic [31:0] e);
	begin
		@(posedge i_mclk);
		ra <= {24'h0, a};
		arv <= 1'h1;
		rp <= 1'h1;
		do @(negedge i_mclk); while (!arr);
		@(posedge i_mclk);
		arv <= 1'h0;
		do @(negedge i_mclk); while (!rv);
		rsp = rrs;
		chk(rd_d, e);
		@(posedge i_mclk);
		rp <= 1'h0;
	end
endtask
task pulse(input int e);
	begin
		@(posedge i_mclk);
		ev[e] <= 1'h1;
		@(posedge i_mclk);
		ev[e] <= 1'h0;
	end
endtask
// Preset flags, optionally sleep, fire one event, check answer and flags
task evt(input int e, input logic s, input logic [7:0] c0, input logic [7:0] ec,
	input logic [7:0] es, input logic r);
	begin
		wr(8'h00, {24'h0, c0});
		wr(8'h04, 32'h18);
		if (s) pulse(9);
		pulse(e);
		@(negedge i_mclk);
		chk({31'h0, crst}, {31'h0, r});
		chk({31'h0, rvld}, 32'h1);
		chk({16'h0, rpc}, r ? 32'h0 : 32'ha6);
		chk({31'h0, vec}, {31'h0, e == 8 && gx});
		rdc(8'h00, {24'h0, ec});
		rdc(8'h04, {24'h0, es});
	end
endtask
// ****
// Tests
// ****
initial
begin
	#250000;
	n_errors++;
	results;
end
initial
begin
	repeat (2) @(posedge i_mclk);
	i_rst <= 1'h0;
	rdc(8'h00, 32'h1c);
	rdc(8'h04, 32'h18);
	rdc(8'h0c, 32'h1);
	$display("test reset done");
	wr(8'h18, 32'h1ff);
	wr(8'h14, 32'h2);
	chk({30'h0, bsp}, 32'h0);
	pulse(2);
	rdc(8'h10, 32'h2);
	chk({31'h0, irq}, 32'h1);
	wr(8'h14, 32'h0);
	chk({31'h0, irq}, 32'h0);
	wr(8'h14, 32'h2);
	wr(8'h18, 32'h2);
	chk({31'h0, irq}, 32'h0);
	rdc(8'h20, 32'h0);
	chk({30'h0, rsp}, 32'h2);
	wr(8'h20, 32'h0);
	chk({30'h0, bsp}, 32'h2);
	$display("test irq done");
	evt(0, 1'h0, 8'h41, 8'h1d, 8'h18, 1'h1);
	evt(1, 1'h0, 8'he3, 8'h3e, 8'h18, 1'h1);
	evt(3, 1'h0, 8'hff, 8'hef, 8'h08, 1'h1);
	evt(4, 1'h0, 8'hff, 8'hcf, 8'h08, 1'h1);
	evt(2, 1'h0, 8'hff, 8'hf7, 8'h18, 1'h1);
	evt(2, 1'h1, 8'hff, 8'hf7, 8'h10, 1'h1);
	evt(5, 1'h0, 8'hff, 8'hfb, 8'h18, 1'h1);
	evt(6, 1'h0, 8'h00, 8'h80, 8'h18, 1'h1);
	evt(7, 1'h0, 8'h00, 8'h40, 8'h18, 1'h1);
	evt(3, 1'h1, 8'h5a, 8'h5a, 8'h00, 1'h0);
	evt(8, 1'h1, 8'ha5, 8'ha5, 8'h10, 1'h0);
	$display("test events done");
	wr(8'h0c, 32'h0);
	rdc(8'h0c, 32'h0);
	wr(8'h00, 32'h0);
	pulse(6);
	@(negedge i_mclk);
	chk({31'h0, rvld}, 32'h0);
	rdc(8'h00, 32'h0);
	wr(8'h0c, 32'h3);
	gx = 1'h1;
	evt(8, 1'h1, 8'h00, 8'h00, 8'h10, 1'h0);
	chk({16'h0, rpc}, 32'h4);
	wr(8'h00, 32'h0);
	rdc(8'h00, 32'h0);
	$display("test vector done");
	results;
end
endmodule
bind rcr_reset_cause_recorder rcr_chk_sva #(.PC_W(PC_W)) u_sva (.*);
`default_nettype wire
